// File: rtl/sleep_wakeup_defines.svh
// Behaviour
// RQ1 - after wake in crystal modes, hold the core for 1024 oscillator periods
// RQ2 - in external clock or resistor-capacitor mode, resume with no start-up hold
// RQ3 - global enable set on wake: branch to program address 0004h
// RQ4 - global enable clear on wake: no vector, continue after the sleep instruction
// RQ5 - unimplemented register bits read zero, writes to them do nothing
// RQ6 - instruction clock pin undriven in all crystal modes and external clock mode
// RQ7 - any source with flag and own enable set wakes, regardless of global enable
`ifndef SLEEP_WAKEUP_DEFINES_SVH
`define SLEEP_WAKEUP_DEFINES_SVH

`define OFS_PORTB_CHANGE_ENABLE  8'h00
`define OFS_CORE_IRQ_CONTROL     8'h04
`define OFS_PERIPH_ENABLE_ONE    8'h08
`define OFS_PERIPH_ENABLE_TWO    8'h0c
`define OFS_PERIPH_FLAG_ONE      8'h10
`define OFS_PERIPH_FLAG_TWO      8'h14
`define OFS_WAKE_CONFIG          8'h18
`define OFS_WAKE_STATUS          8'h1c

`define REG_RESET                8'h00
`define IMPL_MASK_TWO            8'h01

`define BIT_GLOBAL_EN            7
`define BIT_PERIPH_EN            6
`define BIT_T0IE                 5
`define BIT_INTE                 4
`define BIT_RBIE                 3
`define BIT_T0IF                 2
`define BIT_INTF                 1
`define BIT_RBIF                 0

`define OST_PERIODS              1024
`define HCLK_PER_OSC             1
`define OST_CYCLES               (`OST_PERIODS * `HCLK_PER_OSC)
`define WAKE_VECTOR              13'h0004

`endif

// File: rtl/sleep_wakeup_pkg.sv
package sleep_wakeup_pkg;

  typedef enum logic [2:0] {
    low_power_crystal_mode,
    standard_crystal_mode,
    high_speed_crystal_mode,
    external_clock_mode,
    resistor_capacitor_mode
  } osc_mode_type;

  typedef enum logic [1:0] {
    st_run,
    st_sleep,
    st_ost,
    st_resume
  } wake_state_type;

endpackage

// File: rtl/sleep_wakeup_control.sv
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "sleep_wakeup_defines.svh"

module sleep_wakeup_control #(
  parameter int OST_CYCLES = `OST_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        sleep_req,
  input  wire logic        timer_overflow,
  input  wire logic        ext_int_pin,
  input  wire logic [7:0]  portb_pins,
  input  wire logic [7:0]  peripheral_flag_set_one,
  input  wire logic        peripheral_flag_set_two,
  output logic             core_hold,
  output logic             vector_pulse,
  output logic [12:0]      vector_addr,
  output logic             resume_inline,
  output logic             instruction_clock_output,
  output logic             instruction_clock_output_oe
);

  if (OST_CYCLES < 1 || OST_CYCLES > 2048)
  begin : g_bad_ost
    $error("OST_CYCLES must lie in 1..2048");
  end

  localparam logic [10:0] OST_LAST = 11'(OST_CYCLES - 1);

  sleep_wakeup_pkg::wake_state_type state_q;
  sleep_wakeup_pkg::osc_mode_type   osc_mode_q;
  logic [7:0]  change_enable_q;
  logic [7:0]  irq_control_q;
  logic [7:0]  enable_one_q;
  logic [7:0]  enable_two_q;
  logic [7:0]  flag_one_q;
  logic [7:0]  flag_two_q;
  logic [10:0] ost_cnt_q;
  logic        hreadyout_q;
  logic [31:0] hrdata_q;
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [7:0]  addr_q;
  logic        core_hold_q;
  logic        vector_pulse_q;
  logic [12:0] vector_addr_q;
  logic        resume_inline_q;
  logic        clk_out_q;
  logic        clk_oe_q;
  logic [1:0]  clk_div_q;
  logic [7:0]  pb_s1_q;
  logic [7:0]  pb_s2_q;
  logic [7:0]  pb_prev_q;
  logic        ei_s1_q;
  logic        ei_s2_q;
  logic        ei_prev_q;

  logic        accept;
  logic        wr_en;
  logic [7:0]  wdata;
  logic [7:0]  rb_change;
  logic        int_edge;
  logic        wake_src;
  logic        crystal;

  function automatic logic is_write(input logic [7:0] a, input logic [7:0] ofs,
                                    input logic en);
    is_write = en && (a == ofs);
  endfunction

  // flags: a hardware set in the same cycle as a software clear wins
  function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic wr,
                                           input logic [7:0] wd, input logic [7:0] set,
                                           input logic [7:0] mask);
    flag_next = ((wr ? wd : cur) | set) & mask;
  endfunction

  assign accept   = hsel && htrans[1] && hready;
  assign wr_en    = wr_pend_q;
  assign wdata    = hwdata[7:0];
  assign rb_change = (pb_s2_q ^ pb_prev_q) & change_enable_q;
  assign int_edge = ei_s2_q && !ei_prev_q;
  assign crystal  = (osc_mode_q == sleep_wakeup_pkg::low_power_crystal_mode) ||
                    (osc_mode_q == sleep_wakeup_pkg::standard_crystal_mode) ||
                    (osc_mode_q == sleep_wakeup_pkg::high_speed_crystal_mode);
  // global enable deliberately left out so a masked core still wakes
  assign wake_src = (irq_control_q[`BIT_T0IE] && irq_control_q[`BIT_T0IF]) ||
                    (irq_control_q[`BIT_INTE] && irq_control_q[`BIT_INTF]) ||
                    (irq_control_q[`BIT_RBIE] && irq_control_q[`BIT_RBIF]) ||
                    |(enable_one_q & flag_one_q) || |(enable_two_q & flag_two_q);  // [RQ7]

  // pin synchronisers; only the second stage feeds logic
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pb_s1_q   <= `REG_RESET;
      pb_s2_q   <= `REG_RESET;
      pb_prev_q <= `REG_RESET;
      ei_s1_q   <= 1'b0;
      ei_s2_q   <= 1'b0;
      ei_prev_q <= 1'b0;
    end
    else
    begin
      pb_s1_q   <= portb_pins;
      pb_s2_q   <= pb_s1_q;
      pb_prev_q <= pb_s2_q;
      ei_s1_q   <= ext_int_pin;
      ei_s2_q   <= ei_s1_q;
      ei_prev_q <= ei_s2_q;
    end
  end

  // ahb data phase; reads take one wait state so a preceding write is seen
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_q <= 1'b1;
      hrdata_q    <= 32'h0000_0000;
      wr_pend_q   <= 1'b0;
      rd_pend_q   <= 1'b0;
      addr_q      <= 8'h00;
    end
    else
    begin
      wr_pend_q <= accept && hwrite;
      if (accept)
        addr_q <= haddr[7:0];
      if (accept && !hwrite)
      begin
        rd_pend_q   <= 1'b1;
        hreadyout_q <= 1'b0;
      end
      else if (rd_pend_q)
      begin
        rd_pend_q   <= 1'b0;
        hreadyout_q <= 1'b1;
        case (addr_q)
          `OFS_PORTB_CHANGE_ENABLE: hrdata_q <= {24'h000000, change_enable_q};
          `OFS_CORE_IRQ_CONTROL:    hrdata_q <= {24'h000000, irq_control_q};
          `OFS_PERIPH_ENABLE_ONE:   hrdata_q <= {24'h000000, enable_one_q};
          `OFS_PERIPH_ENABLE_TWO:   hrdata_q <= {24'h000000, enable_two_q};  // [RQ5]
          `OFS_PERIPH_FLAG_ONE:     hrdata_q <= {24'h000000, flag_one_q};
          `OFS_PERIPH_FLAG_TWO:     hrdata_q <= {24'h000000, flag_two_q};  // [RQ5]
          `OFS_WAKE_CONFIG:         hrdata_q <= {29'h00000000, osc_mode_q};
          `OFS_WAKE_STATUS:         hrdata_q <= {19'h00000, ost_cnt_q, state_q};
          default:                  hrdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      change_enable_q <= `REG_RESET;
      enable_one_q    <= `REG_RESET;
      enable_two_q    <= `REG_RESET;
      osc_mode_q <= sleep_wakeup_pkg::standard_crystal_mode;
    end
    else
    begin
      if (is_write(addr_q, `OFS_PORTB_CHANGE_ENABLE, wr_en))
        change_enable_q <= wdata;
      if (is_write(addr_q, `OFS_PERIPH_ENABLE_ONE, wr_en))
        enable_one_q <= wdata;
      if (is_write(addr_q, `OFS_PERIPH_ENABLE_TWO, wr_en))
        enable_two_q <= wdata & `IMPL_MASK_TWO;  // [RQ5]
      // codes outside the mode list are ignored
      if (is_write(addr_q, `OFS_WAKE_CONFIG, wr_en) &&
          hwdata[2:0] <= 3'(sleep_wakeup_pkg::resistor_capacitor_mode))
        osc_mode_q <= sleep_wakeup_pkg::osc_mode_type'(hwdata[2:0]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_control_q <= `REG_RESET;
      flag_one_q    <= `REG_RESET;
      flag_two_q    <= `REG_RESET;
    end
    else
    begin
      irq_control_q <= flag_next(irq_control_q, is_write(addr_q, `OFS_CORE_IRQ_CONTROL, wr_en),
                                 wdata, {5'h00, timer_overflow, int_edge, |rb_change}, 8'hff);
      // vectoring masks further interrupts until software sets the enable again
      if (state_q == sleep_wakeup_pkg::st_resume && irq_control_q[`BIT_GLOBAL_EN])
        irq_control_q[`BIT_GLOBAL_EN] <= 1'b0;
      flag_one_q <= flag_next(flag_one_q, is_write(addr_q, `OFS_PERIPH_FLAG_ONE, wr_en), wdata,
                              peripheral_flag_set_one, 8'hff);
      flag_two_q <= flag_next(flag_two_q, is_write(addr_q, `OFS_PERIPH_FLAG_TWO, wr_en), wdata,
                              {7'h00, peripheral_flag_set_two}, `IMPL_MASK_TWO);  // [RQ5]
    end
  end

  // sleep and wake sequencing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q         <= sleep_wakeup_pkg::st_run;
      ost_cnt_q       <= 11'h000;
      core_hold_q     <= 1'b0;
      vector_pulse_q  <= 1'b0;
      vector_addr_q   <= 13'h0000;
      resume_inline_q <= 1'b0;
    end
    else
    begin
      vector_pulse_q  <= 1'b0;
      resume_inline_q <= 1'b0;
      case (state_q)
        sleep_wakeup_pkg::st_run:
          if (sleep_req)
          begin
            state_q     <= sleep_wakeup_pkg::st_sleep;
            core_hold_q <= 1'b1;
          end
        sleep_wakeup_pkg::st_sleep:
          if (wake_src)  // [RQ7]
          begin
            ost_cnt_q <= 11'h000;
            if (crystal)
              state_q <= sleep_wakeup_pkg::st_ost;  // [RQ1]
            else
              state_q <= sleep_wakeup_pkg::st_resume;  // [RQ2]
          end
        sleep_wakeup_pkg::st_ost:
          if (ost_cnt_q == OST_LAST)
            state_q <= sleep_wakeup_pkg::st_resume;  // [RQ1]
          else
            ost_cnt_q <= ost_cnt_q + 11'h001;
        sleep_wakeup_pkg::st_resume:
        begin
          state_q     <= sleep_wakeup_pkg::st_run;
          core_hold_q <= 1'b0;
          if (irq_control_q[`BIT_GLOBAL_EN])
          begin
            vector_pulse_q <= 1'b1;  // [RQ3]
            vector_addr_q  <= `WAKE_VECTOR;
          end
          else
            resume_inline_q <= 1'b1;  // [RQ4]
        end
        default:
          state_q <= sleep_wakeup_pkg::st_run;
      endcase
    end
  end

  // instruction clock only in resistor-capacitor mode; the oscillator is halted while asleep
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_div_q <= 2'b00;
      clk_out_q <= 1'b0;
      clk_oe_q  <= 1'b0;
    end
    else
    begin
      clk_oe_q <= (osc_mode_q == sleep_wakeup_pkg::resistor_capacitor_mode);  // [RQ6]
      if (state_q == sleep_wakeup_pkg::st_run)
      begin
        clk_div_q <= clk_div_q + 2'b01;
        if (clk_div_q[0])
          clk_out_q <= !clk_out_q;
      end
    end
  end

  assign hreadyout                   = hreadyout_q;
  assign hrdata                      = hrdata_q;
  assign hresp                       = 1'b0;
  assign core_hold                   = core_hold_q;
  assign vector_pulse                = vector_pulse_q;
  assign vector_addr                 = vector_addr_q;
  assign resume_inline               = resume_inline_q;
  assign instruction_clock_output    = clk_out_q;
  assign instruction_clock_output_oe = clk_oe_q;

  sequence resume_step_s;
    state_q == sleep_wakeup_pkg::st_resume;
  endsequence

  sequence read_wait_s;
    !hreadyout_q ##1 hreadyout_q;
  endsequence

  ost_length_a: assert property (  // [RQ1]
    @(posedge hclk) disable iff (!hresetn)
    $fell(state_q == sleep_wakeup_pkg::st_ost) |-> $past(ost_cnt_q) == OST_LAST)
    else $error("start-up hold ended at the wrong count");

  no_ost_skip_a: assert property (  // [RQ2]
    @(posedge hclk) disable iff (!hresetn)
    state_q == sleep_wakeup_pkg::st_sleep && wake_src && !crystal
    |=> state_q == sleep_wakeup_pkg::st_resume ##1 !core_hold_q)
    else $error("non-crystal wake did not resume at once");

  vector_jump_a: assert property (  // [RQ3]
    @(posedge hclk) disable iff (!hresetn)
    resume_step_s ##0 irq_control_q[`BIT_GLOBAL_EN]
    |=> vector_pulse_q && vector_addr_q == `WAKE_VECTOR && !irq_control_q[`BIT_GLOBAL_EN])
    else $error("wake with global enable did not vector");

  inline_resume_a: assert property (  // [RQ4]
    @(posedge hclk) disable iff (!hresetn)
    resume_step_s ##0 !irq_control_q[`BIT_GLOBAL_EN] |=> resume_inline_q && !vector_pulse_q)
    else $error("wake without global enable vectored");

  unimpl_zero_a: assert property (  // [RQ5]
    @(posedge hclk) disable iff (!hresetn)
    enable_two_q[7:1] == 7'h00 && flag_two_q[7:1] == 7'h00)
    else $error("unimplemented bit became set");

  clock_pin_off_a: assert property (  // [RQ6]
    @(posedge hclk) disable iff (!hresetn)
    osc_mode_q != sleep_wakeup_pkg::resistor_capacitor_mode |=> !clk_oe_q)
    else $error("instruction clock driven outside resistor-capacitor mode");

  wake_source_a: assert property (  // [RQ7]
    @(posedge hclk) disable iff (!hresetn)
    state_q == sleep_wakeup_pkg::st_sleep && wake_src
    |=> state_q != sleep_wakeup_pkg::st_sleep && core_hold_q)
    else $error("enabled source failed to wake");

  read_wait_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    accept && !hwrite |=> read_wait_s)
    else $error("read wait state missing");

endmodule

// File: sim/irq_source_model.sv
`timescale 1ns/100ps

module irq_source_model (
  input  wire logic       hclk,
  input  wire logic       fire,
  input  wire logic [2:0] src,
  input  wire logic [2:0] pick,
  output logic            timer_overflow,
  output logic            ext_int_pin,
  output logic [7:0]      portb_pins,
  output logic [7:0]      flag_set_one,
  output logic            flag_set_two
);
  initial
  begin
    timer_overflow = 1'b0;
    ext_int_pin    = 1'b0;
    portb_pins     = 8'h00;
    flag_set_one   = 8'h00;
    flag_set_two   = 1'b0;
  end

  // same-clock sources pulse once; pins hold their new level as a real pad would
  always @(posedge hclk)
  begin
    timer_overflow <= fire && src == 3'd0;
    flag_set_one   <= (fire && src == 3'd3) ? (8'h01 << pick) : 8'h00;
    flag_set_two   <= fire && src == 3'd4;
    if (fire)
      ext_int_pin <= (src == 3'd1);
    if (fire && src == 3'd2)
      portb_pins[pick] <= ~portb_pins[pick];
  end
endmodule

// File: sim/testbench.sv
`timescale 1ns/100ps
`include "sleep_wakeup_defines.svh"

module testbench;
  localparam int OST = 8;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, sleep_req, fire;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  src, pick;
  logic        tov, ext_pin, fs_two, core_hold, vpulse, inline_pulse, ick, ick_oe;
  logic [7:0]  pb_pins, fs_one;
  logic [12:0] vaddr;
  int          fails, checks;

  irq_source_model irq_source_model_inst (.hclk(hclk), .fire(fire), .src(src), .pick(pick),
    .timer_overflow(tov), .ext_int_pin(ext_pin), .portb_pins(pb_pins),
    .flag_set_one(fs_one), .flag_set_two(fs_two));

  sleep_wakeup_control #(.OST_CYCLES(OST)) sleep_wakeup_control_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .sleep_req(sleep_req), .timer_overflow(tov),
    .ext_int_pin(ext_pin), .portb_pins(pb_pins), .peripheral_flag_set_one(fs_one),
    .peripheral_flag_set_two(fs_two), .core_hold(core_hold), .vector_pulse(vpulse),
    .vector_addr(vaddr), .resume_inline(inline_pulse), .instruction_clock_output(ick),
    .instruction_clock_output_oe(ick_oe));

  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task print_verdict();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // waits are bounded so a stuck ready cannot hang the run
  task bus(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] rd);
    int n;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100)
    begin
      fails++;
      print_verdict();
    end
  endtask

  task wake(input int m, input int s, input logic g);
    logic [31:0] rd;
    int          n;
    logic [2:0]  p;
    logic        ick_prev;
    p = 3'($urandom_range(7));
    pick <= p;
    bus(1'b1, `OFS_WAKE_CONFIG, 8'(m), rd);
    bus(1'b1, `OFS_PORTB_CHANGE_ENABLE, 8'h01 << p, rd);
    bus(1'b1, `OFS_PERIPH_ENABLE_ONE, 8'h01 << p, rd);
    bus(1'b1, `OFS_PERIPH_ENABLE_TWO, 8'h01, rd);
    bus(1'b1, `OFS_CORE_IRQ_CONTROL, {g, 1'b0, s == 0, s == 1, s == 2, 3'b000}, rd);
    chk("clk_out_oe", m == 4, ick_oe);
    if (m == 4)
    begin
      ick_prev = ick;
      repeat (2) @(posedge hclk);
      chk("clk_toggle", !ick_prev, ick);
    end
    sleep_req <= 1'b1;
    @(posedge hclk);
    sleep_req <= 1'b0;
    repeat (2) @(posedge hclk);
    if (s != 0)
    begin
      src  <= 3'd0;
      fire <= 1'b1;
      @(posedge hclk);
      fire <= 1'b0;
      repeat (12) @(posedge hclk);
      chk("hold_unenabled", 1, core_hold);
    end
    src  <= 3'(s);
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
    n = 0;
    while (n < 3000)
    begin
      @(posedge hclk);
      #1;
      n++;
      if (vpulse === 1'b1 || inline_pulse === 1'b1)
        break;
    end
    if (n >= 3000)
    begin
      fails++;
      print_verdict();
    end
    // pin sources add synchroniser delay, so only same-clock sources are timed exactly
    if (s == 0 || s > 2)
      chk("wake_cycles", (m < 3 ? OST : 0) + 3, 32'(n));
    chk("vector_pulse", g, vpulse);
    chk("resume_inline", !g, inline_pulse);
    chk("hold_released", 0, core_hold);
    if (g)
      chk("vector_addr", 32'(`WAKE_VECTOR), vaddr);
    bus(1'b1, `OFS_CORE_IRQ_CONTROL, 8'h00, rd);
    bus(1'b1, `OFS_PERIPH_FLAG_ONE, 8'h00, rd);
    bus(1'b1, `OFS_PERIPH_FLAG_TWO, 8'h00, rd);
  endtask

  initial
  begin
    logic [31:0] rd;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    sleep_req = 1'b0;
    fire = 1'b0;
    src = 3'd0;
    pick = 3'd0;
    fails = 0;
    checks = 0;
    void'($urandom(32'h2c04));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, 8'(4 * i), 8'h00, rd);
      chk("reset_value", 0, rd);
      chk("hresp", 0, hresp);
    end
    bus(1'b1, `OFS_PERIPH_ENABLE_TWO, 8'hff, rd);
    bus(1'b0, `OFS_PERIPH_ENABLE_TWO, 8'h00, rd);
    chk("enable_two", `IMPL_MASK_TWO, rd);
    bus(1'b1, `OFS_PERIPH_FLAG_TWO, 8'hfe, rd);
    bus(1'b0, `OFS_PERIPH_FLAG_TWO, 8'h00, rd);
    chk("flag_two", 0, rd);
    bus(1'b1, 8'h40, 8'h5a, rd);
    bus(1'b0, 8'h40, 8'h00, rd);
    chk("unmapped", 0, rd);
    for (int t = 0; t < 14; t++)
      wake(t % 5, (t < 5) ? t : $urandom_range(4), t == 1 || $urandom_range(1) == 1);
    print_verdict();
  end
endmodule
